// *** logic/icu_pkg.sv ***
// icu_pkg: register map, field layout and types of the input capture unit
// assumes a single clock domain and the plain strobe register port
package icu_pkg;

   // ----------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] ICU_OFF_CTRL = 8'h00;
   localparam logic [7:0] ICU_OFF_CLR = 8'h04;
   localparam logic [7:0] ICU_OFF_SET = 8'h08;
   localparam logic [7:0] ICU_OFF_INV = 8'h0C;
   localparam logic [7:0] ICU_OFF_BUF = 8'h10;
   localparam logic [7:0] ICU_OFF_IRQ_STAT = 8'h20;
   localparam logic [7:0] ICU_OFF_IRQ_CLR = 8'h24;
   localparam logic [7:0] ICU_OFF_IRQ_EN = 8'h28;
   localparam logic [7:0] ICU_OFF_TB0 = 8'h30;
   localparam logic [7:0] ICU_OFF_TB1 = 8'h34;

   // ----------------------------------------
   // control field positions
   // ----------------------------------------
   localparam int ICU_B_MODE = 0;
   localparam int ICU_B_BNE = 3;
   localparam int ICU_B_OVF = 4;
   localparam int ICU_B_EPI = 5;
   localparam int ICU_B_TBSEL = 7;
   localparam int ICU_B_WIDE = 8;
   localparam int ICU_B_FEDGE = 9;
   localparam int ICU_B_IDLE = 13;
   localparam int ICU_B_FREEZE = 14;
   localparam int ICU_B_ON = 15;
   // writable bits of the control register; status bits excluded
   localparam logic [31:0] ICU_CTRL_WMASK = 32'h0000_E3E7;
   localparam logic [31:0] ICU_CTRL_RST = 32'h0000_0000;

   // interrupt status bits
   localparam int ICU_IRQ_CAP = 0;
   localparam int ICU_IRQ_WAKE = 1;
   localparam int ICU_IRQ_OVF = 2;
   localparam int ICU_IRQ_N = 3;

   localparam int ICU_FIFO_DEPTH = 4;
   localparam int ICU_PRESC4 = 4;
   localparam int ICU_PRESC16 = 16;

   typedef enum logic [2:0] {
      ICU_M_OFF = 3'h0, ICU_M_FIRST = 3'h1, ICU_M_FALL = 3'h2, ICU_M_RISE = 3'h3,
      ICU_M_R4 = 3'h4, ICU_M_R16 = 3'h5, ICU_M_BOTH = 3'h6, ICU_M_WAKE = 3'h7
   } icu_mode_type;

   // first-edge mode progress, one-hot
   typedef enum logic [1:0] {
      ICU_S_WAIT = 2'b01,
      ICU_S_ALL = 2'b10
   } icu_state_type;

   // register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } icu_req_type;

   // priority settings held beside the flag for the interrupt controller
   typedef struct packed {
      logic [2:0] prio;
      logic [1:0] subprio;
   } icu_prio_type;

endpackage : icu_pkg

// *** logic/icu_top.sv ***
// icu_top: input capture unit with control aliases, four-entry fifo and interrupts
// assumes both time bases and the register port run on i_mclk; capture pin is async
//
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps

module icu_top #(
   parameter int DEPTH = icu_pkg::ICU_FIFO_DEPTH,
   parameter int TW = 32
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_capture_input,
   input wire logic i_sleep,
   input wire logic [TW-1:0] i_timebase0,
   input wire logic [TW-1:0] i_timebase1,
   input wire icu_pkg::icu_req_type i_req,
   output logic [31:0] o_rdata,
   output logic o_irq,
   output icu_pkg::icu_prio_type o_prio
);
   import icu_pkg::*;

   localparam int AW = $clog2(DEPTH);

   // ----------------------------------------
   // capture pin synchroniser and edges
   // ----------------------------------------
   logic sync1_r, sync2_r, last_r;
   logic sync1_nxt, sync2_nxt, last_nxt;
   logic rise, fall;

   // first stage is read only by the second stage
   always_comb begin
      sync1_nxt = i_capture_input;
      sync2_nxt = sync1_r;
      last_nxt = sync2_r;
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         last_r <= 1'b0;
      end else begin
         sync1_r <= sync1_nxt;
         sync2_r <= sync2_nxt;
         last_r <= last_nxt;
      end
   end

   assign rise = sync2_r & ~last_r;
   assign fall = ~sync2_r & last_r;

   // ----------------------------------------
   // register state
   // ----------------------------------------
   logic [31:0] ctrl_r, ctrl_nxt;
   logic [ICU_IRQ_N-1:0] stat_r, stat_nxt, en_r, en_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic irq_r, irq_nxt;
   icu_prio_type prio_r, prio_nxt;
   icu_state_type st_r, st_nxt;
   logic [3:0] presc_r, presc_nxt;
   logic [1:0] evcnt_r, evcnt_nxt;
   logic [TW-1:0] mem_r [DEPTH];
   logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [AW:0] cnt_r, cnt_nxt;
   logic ovf_r, ovf_nxt;

   icu_mode_type mode;
   logic on, cap, push, pop, wake;
   logic [TW-1:0] tsel;
   logic wr_ctrl, wr_clr, wr_set, wr_inv, rd_buf;

   assign mode = icu_mode_type'(ctrl_r[ICU_B_MODE +: 3]);
   assign on = ctrl_r[ICU_B_ON];
   assign tsel = ctrl_r[ICU_B_TBSEL] ? i_timebase1 : i_timebase0;

   // address decode
   always_comb begin
      wr_ctrl = 1'b0;
      wr_clr = 1'b0;
      wr_set = 1'b0;
      wr_inv = 1'b0;
      if (i_req.wr && i_req.addr == ICU_OFF_CTRL) begin
         wr_ctrl = 1'b1;
      end else if (i_req.wr && i_req.addr == ICU_OFF_CLR) begin
         wr_clr = 1'b1;
      end else if (i_req.wr && i_req.addr == ICU_OFF_SET) begin
         wr_set = 1'b1;
      end else if (i_req.wr && i_req.addr == ICU_OFF_INV) begin
         wr_inv = 1'b1;
      end
   end

   assign rd_buf = i_req.rd && i_req.addr == ICU_OFF_BUF;

   // ----------------------------------------
   // capture event decision
   // ----------------------------------------
   // prescaler counts rises only; cleared when mode is not prescaled
   always_comb begin
      cap = 1'b0;
      wake = 1'b0;
      st_nxt = st_r;
      presc_nxt = presc_r;
      case (mode)
         ICU_M_FALL: cap = fall;
         ICU_M_RISE: cap = rise;
         ICU_M_R4: begin
            if (rise) begin
               presc_nxt = presc_r + 4'h1;
               cap = presc_r == 4'(ICU_PRESC4 - 1);
               if (cap) presc_nxt = 4'h0;
            end
         end
         ICU_M_R16: begin
            if (rise) begin
               presc_nxt = presc_r + 4'h1; // wraps after sixteen
               cap = presc_r == 4'(ICU_PRESC16 - 1);
            end
         end
         ICU_M_BOTH: cap = rise | fall;
         ICU_M_FIRST: begin
            case (st_r)
               ICU_S_WAIT: begin
                  cap = ctrl_r[ICU_B_FEDGE] ? rise : fall;
                  if (cap) st_nxt = ICU_S_ALL;
               end
               ICU_S_ALL: cap = rise | fall;
               default: st_nxt = ICU_S_WAIT;
            endcase
         end
         ICU_M_WAKE: wake = rise & i_sleep;
         default: ;
      endcase
      if (!on) begin
         cap = 1'b0;
         wake = 1'b0;
      end
      if (!on || mode != ICU_M_FIRST) st_nxt = ICU_S_WAIT;
      if (!on || (mode != ICU_M_R4 && mode != ICU_M_R16)) presc_nxt = 4'h0;
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         st_r <= ICU_S_WAIT;
         presc_r <= 4'h0;
      end else begin
         st_r <= st_nxt;
         presc_r <= presc_nxt;
      end
   end

   // ----------------------------------------
   // fifo
   // ----------------------------------------
   // full fifo refuses the new value so older entries survive
   assign push = cap && cnt_r != (AW+1)'(DEPTH);
   assign pop = rd_buf && cnt_r != '0;

   always_comb begin
      wp_nxt = push ? wp_r + AW'(1) : wp_r;
      rp_nxt = pop ? rp_r + AW'(1) : rp_r;
      cnt_nxt = cnt_r;
      if (push && !pop) cnt_nxt = cnt_r + (AW+1)'(1);
      if (pop && !push) cnt_nxt = cnt_r - (AW+1)'(1);
      // overflow is sticky; writing zero to it via the status bit clears it,
      // an overflow in the same cycle wins
      ovf_nxt = ovf_r;
      if (wr_ctrl && !i_req.wdata[ICU_B_OVF]) ovf_nxt = 1'b0; // cleared by writing zero, never set by software
      if (wr_clr && i_req.wdata[ICU_B_OVF]) ovf_nxt = 1'b0;
      if (!on) ovf_nxt = 1'b0;
      if (cap && !push) ovf_nxt = 1'b1;
   end

   always_ff @(posedge i_mclk) begin
      if (push) mem_r[wp_r] <= tsel;
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
         ovf_r <= 1'b0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
         ovf_r <= ovf_nxt;
      end
   end

   // ----------------------------------------
   // control register and aliases
   // ----------------------------------------
   always_comb begin
      ctrl_nxt = ctrl_r;
      if (wr_ctrl) ctrl_nxt = i_req.wdata & ICU_CTRL_WMASK;
      if (wr_clr) ctrl_nxt = ctrl_r & ~(i_req.wdata & ICU_CTRL_WMASK);
      if (wr_set) ctrl_nxt = ctrl_r | (i_req.wdata & ICU_CTRL_WMASK);
      if (wr_inv) ctrl_nxt = ctrl_r ^ (i_req.wdata & ICU_CTRL_WMASK);
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) ctrl_r <= ICU_CTRL_RST;
      else ctrl_r <= ctrl_nxt;
   end

   // ----------------------------------------
   // interrupts: event count, sticky status, enable
   // ----------------------------------------
   // count wraps at 1..4 captures as the events field says
   always_comb begin
      logic fire;
      fire = 1'b0;
      evcnt_nxt = evcnt_r;
      if (push) begin
         if (evcnt_r == ctrl_r[ICU_B_EPI +: 2]) begin
            fire = 1'b1;
            evcnt_nxt = 2'h0;
         end else begin
            evcnt_nxt = evcnt_r + 2'h1;
         end
      end
      if (!on) evcnt_nxt = 2'h0;
      stat_nxt = stat_r;
      en_nxt = en_r;
      prio_nxt = prio_r;
      if (i_req.wr && i_req.addr == ICU_OFF_IRQ_CLR) begin
         stat_nxt = stat_r & ~i_req.wdata[ICU_IRQ_N-1:0];
      end
      if (i_req.wr && i_req.addr == ICU_OFF_IRQ_EN) begin
         en_nxt = i_req.wdata[ICU_IRQ_N-1:0];
         prio_nxt = i_req.wdata[12:8];
      end
      // set wins over a clear in the same cycle
      if (fire) stat_nxt[ICU_IRQ_CAP] = 1'b1;
      if (wake) stat_nxt[ICU_IRQ_WAKE] = 1'b1;
      if (cap && !push) stat_nxt[ICU_IRQ_OVF] = 1'b1;
      irq_nxt = |(stat_nxt & en_nxt);
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         evcnt_r <= 2'h0;
         stat_r <= '0;
         en_r <= '0;
         prio_r <= '0;
         irq_r <= 1'b0;
      end else begin
         evcnt_r <= evcnt_nxt;
         stat_r <= stat_nxt;
         en_r <= en_nxt;
         prio_r <= prio_nxt;
         irq_r <= irq_nxt;
      end
   end

   // ----------------------------------------
   // read data, one cycle after the strobe
   // ----------------------------------------
   // aliases and unmapped addresses read zero
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (i_req.rd && i_req.addr == ICU_OFF_CTRL) begin
         rdata_nxt = ctrl_r;
         rdata_nxt[ICU_B_BNE] = cnt_r != '0;
         rdata_nxt[ICU_B_OVF] = ovf_r;
      end else if (rd_buf) begin
         if (cnt_r != '0) rdata_nxt = 32'(mem_r[rp_r]);
      end else if (i_req.rd && i_req.addr == ICU_OFF_IRQ_STAT) begin
         rdata_nxt = 32'(stat_r);
      end else if (i_req.rd && i_req.addr == ICU_OFF_IRQ_EN) begin
         rdata_nxt = {19'h0, prio_r, 5'h0, 3'(en_r)};
      end else if (i_req.rd && i_req.addr == ICU_OFF_TB0) begin
         rdata_nxt = 32'(i_timebase0);
      end else if (i_req.rd && i_req.addr == ICU_OFF_TB1) begin
         rdata_nxt = 32'(i_timebase1);
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) rdata_r <= 32'h0000_0000;
      else rdata_r <= rdata_nxt;
   end

   assign o_rdata = rdata_r;
   assign o_irq = irq_r;
   assign o_prio = prio_r;

endmodule // icu_top

// *** dv/icu_top_assertions.sv ***
// icu_top_assertions: port-level checks of the input capture unit
// assumes one clock i_mclk and synchronous active-high i_rst
`timescale 1ns/100ps
module icu_chk #(
   parameter int TW = 32
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_capture_input,
   input wire logic i_sleep,
   input wire logic [TW-1:0] i_timebase0,
   input wire logic [TW-1:0] i_timebase1,
   input wire icu_pkg::icu_req_type i_req,
   input wire logic [31:0] o_rdata,
   input wire logic o_irq,
   input wire icu_pkg::icu_prio_type o_prio
);
   import icu_pkg::*;
   // ----
   // shadows
   // ----
   logic [31:0] sh;
   logic [2:0] en;
   logic [4:0] pr;
   logic [1:0] age;
   // age counts edges since the last enable write, so settled outputs are judged
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         sh <= 32'h0;
         en <= 3'h0;
         pr <= 5'h0;
         age <= 2'h0;
      end else begin
         if (age != 2'h3) age <= age + 2'h1;
         if (i_req.wr) begin
            case (i_req.addr)
               ICU_OFF_CTRL: sh <= i_req.wdata & ICU_CTRL_WMASK;
               ICU_OFF_CLR: sh <= sh & ~i_req.wdata;
               ICU_OFF_SET: sh <= sh | (i_req.wdata & ICU_CTRL_WMASK);
               ICU_OFF_INV: sh <= sh ^ (i_req.wdata & ICU_CTRL_WMASK);
               ICU_OFF_IRQ_EN: begin
                  en <= i_req.wdata[2:0];
                  pr <= i_req.wdata[12:8];
                  age <= 2'h0;
               end
               default: ;
            endcase
         end
      end
   end
   // ----
   // properties
   // ----
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   sequence s_wake_arm;
      $rose(i_capture_input) && i_sleep && sh[2:0] == 3'h7 && sh[15] && en[1] && age == 2'h3;
   endsequence
   property p_rd_idle; !i_req.rd |=> o_rdata == 32'h0; endproperty
   property p_unimp; i_req.rd && i_req.addr == ICU_OFF_CTRL |=> (o_rdata & ~32'h0000_E3FF) == 32'h0;
   endproperty
   property p_ctrl; i_req.rd && i_req.addr == ICU_OFF_CTRL |=> (o_rdata & ICU_CTRL_WMASK) == sh;
   endproperty
   property p_prio; age == 2'h3 |-> o_prio == pr; endproperty
   property p_mask; en == 3'h0 && age == 2'h3 |-> !o_irq; endproperty
   property p_wake; s_wake_arm |-> ##[1:8] o_irq; endproperty
   property p_tb0; i_req.rd && i_req.addr == ICU_OFF_TB0 |=> o_rdata == 32'($past(i_timebase0));
   endproperty
   property p_tb1; i_req.rd && i_req.addr == ICU_OFF_TB1 |=> o_rdata == 32'($past(i_timebase1));
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
   a_unimp: assert property (p_unimp) else $error("unused control bit set");
   a_ctrl: assert property (p_ctrl) else $error("control value wrong");
   a_prio: assert property (p_prio) else $error("priority output wrong");
   a_mask: assert property (p_mask) else $error("masked interrupt high");
   a_wake: assert property (p_wake) else $error("no wake interrupt");
   a_tb0: assert property (p_tb0) else $error("time base 0 read wrong");
   a_tb1: assert property (p_tb1) else $error("time base 1 read wrong");
endmodule // icu_chk

// *** dv/icu_far.sv ***
// icu_far: capture pin driver and two stepped time bases
// assumes the bench steps the time bases only while the pin is settled
`timescale 1ns/100ps
module icu_far (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_step,
   input wire logic i_level,
   output logic [31:0] o_tb0,
   output logic [31:0] o_tb1,
   output logic o_pin
);
   // ----
   // time bases
   // ----
   // stepped, not free running, so every capture value is known exactly
   always_ff @(posedge i_mclk) begin
      if (i_rst) o_tb0 <= 32'h0;
      else if (i_step) o_tb0 <= o_tb0 + 32'h1;
      o_pin <= i_level;
   end
   assign o_tb1 = ~o_tb0;
endmodule // icu_far

// *** dv/icu_top_tb.sv ***
// icu_top_tb: register-port tests of the input capture unit
// assumes the far-side model supplies the pin and both time bases
`timescale 1ns/100ps
module icu_top_tb;
   import icu_pkg::*;
   logic mclk = 0, rst = 1, sleep = 0, lvl = 0, step = 0, pin;
   logic [31:0] tb0, tb1, rdata, n = 0;
   icu_req_type req = '0;
   logic irq;
   icu_prio_type prio;
   int n_fail = 0, compares = 0;
   icu_top icu_top_inst (.i_mclk(mclk), .i_rst(rst), .i_capture_input(pin), .i_sleep(sleep),
      .i_timebase0(tb0), .i_timebase1(tb1), .i_req(req), .o_rdata(rdata), .o_irq(irq),
      .o_prio(prio));
   icu_far icu_far_inst (.i_mclk(mclk), .i_rst(rst), .i_step(step), .i_level(lvl),
      .o_tb0(tb0), .o_tb1(tb1), .o_pin(pin));
   // ----
   // access tasks
   // ----
   initial forever #4 mclk = ~mclk;
   task check(input logic [31:0] s, e);
      compares++;
      if (s !== e) begin
         n_fail++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task summarize();
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk) req.wr <= 1'b0;
   endtask
   // alias addresses are only ever written; what they read back means nothing
   task rc(input logic [7:0] a, input logic [31:0] m, e);
      @(posedge mclk) req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge mclk) req.rd <= 1'b0;
      #1 check(rdata & m, e);
   endtask
   // one pin edge, then a time base step once the capture has landed
   task tog();
      @(posedge mclk) lvl <= ~lvl;
      repeat (8) @(posedge mclk);
      step <= 1'b1;
      @(posedge mclk) step <= 1'b0;
      n++;
   endtask
   // k edges in mode m, expected fifo built alongside, then drained
   task automatic run(input icu_mode_type m, input logic fe, tb, input int k);
      logic [31:0] q[$];
      logic ovf, seen, hit;
      int r;
      ovf = 0;
      seen = 0;
      r = 0;
      wr(ICU_OFF_CTRL, 32'h8000 | (32'(fe) << 9) | (32'(tb) << 7) | 32'(m));
      for (int i = 0; i < k; i++) begin
         if (!lvl) r++;
         case (m)
            ICU_M_FALL: hit = lvl;
            ICU_M_RISE: hit = !lvl;
            ICU_M_R4: hit = !lvl && r % 4 == 0;
            ICU_M_R16: hit = !lvl && r % 16 == 0;
            ICU_M_FIRST: hit = seen || (!lvl == fe);
            default: hit = 1;
         endcase
         seen = seen | hit;
         if (hit && q.size() < 4) q.push_back(tb ? ~n : n);
         else if (hit) ovf = 1;
         tog();
      end
      rc(ICU_OFF_CTRL, 32'h10, {27'h0, ovf, 4'h0});
      while (q.size() > 0) rc(ICU_OFF_BUF, '1, q.pop_front());
      rc(ICU_OFF_CTRL, 32'h08, 32'h0);
      rc(ICU_OFF_BUF, '1, 32'h0);
      wr(ICU_OFF_CTRL, 32'h0);
   endtask
   // ----
   // tests
   // ----
   initial begin
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      rc(ICU_OFF_CTRL, '1, 32'h0);
      wr(ICU_OFF_CTRL, '1);
      rc(ICU_OFF_CTRL, '1, 32'h0000_E3E7);
      wr(ICU_OFF_CLR, 32'h7);
      rc(ICU_OFF_CTRL, '1, 32'h0000_E3E0);
      wr(ICU_OFF_SET, 32'h3);
      rc(ICU_OFF_CTRL, '1, 32'h0000_E3E3);
      wr(ICU_OFF_INV, 32'h8001);
      rc(ICU_OFF_CTRL, '1, 32'h0000_63E2);
      rc(8'h3C, '1, 32'h0);
      wr(ICU_OFF_CTRL, 32'h0);
      run(ICU_M_FALL, 0, 0, 8);
      run(ICU_M_RISE, 0, 1, 6);
      run(ICU_M_R4, 0, 0, 16);
      run(ICU_M_R16, 0, 0, 32);
      run(ICU_M_BOTH, 0, 0, 6);
      run(ICU_M_FIRST, 0, 0, 4);
      run(ICU_M_FIRST, 1, 0, 4);
      rc(ICU_OFF_TB0, '1, n);
      rc(ICU_OFF_TB1, '1, ~n);
      // two captures per interrupt; first capture alone must stay quiet
      // status left over from the mode runs must not leak into the count test
      wr(ICU_OFF_IRQ_CLR, 32'h7);
      wr(ICU_OFF_IRQ_EN, 32'h1501);
      wr(ICU_OFF_CTRL, 32'h8023);
      tog();
      tog();
      #1 check(irq, 1'b0);
      tog();
      tog();
      #1 check(irq, 1'b1);
      rc(ICU_OFF_IRQ_STAT, 32'h1, 32'h1);
      check(prio, 5'h15);
      wr(ICU_OFF_IRQ_CLR, 32'h7);
      repeat (2) @(posedge mclk);
      #1 check(irq, 1'b0);
      wr(ICU_OFF_IRQ_EN, 32'h1502);
      wr(ICU_OFF_CTRL, 32'h8007);
      sleep <= 1'b1;
      tog();
      #1 check(irq, 1'b1);
      summarize();
   end
   // ----
   // watchdog
   // ----
   initial begin
      #100000;
      n_fail++;
      summarize();
   end
endmodule // icu_top_tb
bind icu_top icu_chk #(.TW(TW)) icu_chk_inst (.i_mclk(i_mclk), .i_rst(i_rst),
   .i_capture_input(i_capture_input), .i_sleep(i_sleep), .i_timebase0(i_timebase0),
   .i_timebase1(i_timebase1), .i_req(i_req), .o_rdata(o_rdata), .o_irq(o_irq),
   .o_prio(o_prio));
